// ---- design/vcs_fifo.sv ----
// Purpose: synchronous word FIFO between capture and memory writer
// Assumes: power-of-two depth, single clock
// Notes:   flush empties it in one cycle
`default_nettype none

module vcs_fifo #(
    parameter int W     = 16,
    parameter int DEPTH = 16
) (
    // clock and reset
    input  wire logic         clk,
    input  wire logic         rstn,
    input  wire logic         flush,
    // fill side
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    // drain side
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic [W-1:0]      out_data
);
    localparam int AW = $clog2(DEPTH);

    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("vcs_fifo depth must be a power of two of at least 2");
    end

    logic [W-1:0]  mem_q [DEPTH];
    logic [AW-1:0] wr_q;
    logic [AW-1:0] rd_q;
    logic [AW:0]   cnt_q;
    logic          push;
    logic          pop;

    ////////////////////////////////////////////////////////////////////////
    // honest full and empty from the fill count
    assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
    assign out_valid = (cnt_q != '0);
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;
    assign out_data  = mem_q[rd_q];

    // storage array
    always_ff @(posedge clk) begin
        if (push) begin
            mem_q[wr_q] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else if (flush) begin
            wr_q  <= '0;
            rd_q  <= '0;
            cnt_q <= '0;
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            cnt_q <= cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end

endmodule // vcs_fifo

`default_nettype wire

// ---- design/vcs_pkg.sv ----
// Purpose: shared types and constants of the capture control sequencer
// Assumes: one capture channel per instance, 200 MHz clk
// Notes:   control bits are plain ports, no register bus
`default_nettype none

package vcs_pkg;

    localparam int DATA_W     = 16;     // pixel word width
    localparam int FIFO_DEPTH = 16;     // words buffered toward memory

    // fields of the main control word that deferred update covers
    typedef struct packed {
        logic [1:0] clamp_field;
        logic       digital_pin_input_enable;
        logic       field_output_control;
        logic       lookup_table_enable;
        logic       image_processing_enable;
        logic       scaler_enable;
    } vcs_cfg_t;

    localparam vcs_cfg_t CFG_RST = 7'h00;

    // one pixel sample with its frame and line qualifiers
    typedef struct packed {
        logic              frame;
        logic              line;
        logic [DATA_W-1:0] data;
    } vcs_pix_t;

    localparam vcs_pix_t PIX_RST = '0;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ARM,
        ST_FRAME
    } vcs_state_t;

endpackage : vcs_pkg

`default_nettype wire

// ---- design/vcs_sequencer.sv ----
// Purpose: capture control, deferred update and frame sequencing
// Assumes: pin clock far slower than clk, serial stream on clk
// Notes:   pixel processing itself lies outside this block
`default_nettype none

module vcs_sequencer #(
    parameter int DATA_W     = vcs_pkg::DATA_W,
    parameter int FIFO_DEPTH = vcs_pkg::FIFO_DEPTH
) (
    // clock and reset
    input  wire logic             clk,
    input  wire logic             rstn,
    // software control bits
    input  wire logic             module_enable,
    input  wire logic             continuous_capture,
    input  wire logic             single_capture,
    input  wire logic             internal_update_mode,
    input  wire vcs_pkg::vcs_cfg_t main_control_cfg,
    input  wire logic             sync_field_toggle_enable,
    // clock controller
    input  wire logic             module_stop_request,
    input  wire logic             soft_reset_assert,
    input  wire logic             soft_reset_release,
    output logic                  module_stop_state,
    // status
    output logic                  capture_active,
    output vcs_pkg::vcs_cfg_t     active_cfg,
    output logic                  field_id,
    output logic                  overflow,
    // parallel camera pins
    input  wire logic             pin_clk,
    input  wire logic             pin_vsync,
    input  wire logic             pin_hsync,
    input  wire logic [DATA_W-1:0] pin_data,
    // serial receiver stream
    input  wire logic             csi_valid,
    output logic                  csi_ready,
    input  wire vcs_pkg::vcs_pix_t csi_pix,
    // captured words
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic [DATA_W-1:0]     out_data
);
    if (DATA_W != vcs_pkg::DATA_W) begin : g_bad_width
        $error("vcs_sequencer data width must match the package pixel type");
    end

    vcs_pkg::vcs_state_t state_q;
    vcs_pkg::vcs_cfg_t   cfg_q;
    vcs_pkg::vcs_pix_t   pin_s1_q, pin_s2_q;
    logic                pclk_s1_q, pclk_s2_q, pclk_d_q;
    logic                sreset_q, sc_done_q, frame_d_q, stop_q, ovf_q, field_q;
    logic                pin_stb, src_stb, src_frame, src_line;
    logic [DATA_W-1:0]   src_data;
    logic                sof, eof, go, wr_want, fifo_in_ready;

    ////////////////////////////////////////////////////////////////////////
    // pin inputs: two flops, then pin clock edge detect on second stage
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pclk_s1_q <= 1'b0;
            pclk_s2_q <= 1'b0;
            pclk_d_q  <= 1'b0;
            pin_s1_q  <= vcs_pkg::PIX_RST;
            pin_s2_q  <= vcs_pkg::PIX_RST;
        end else begin
            pclk_s1_q <= pin_clk;
            pclk_s2_q <= pclk_s1_q;
            pclk_d_q  <= pclk_s2_q;
            pin_s1_q  <= {pin_vsync, pin_hsync, pin_data};
            pin_s2_q  <= pin_s1_q;
        end
    end

    assign pin_stb = pclk_s2_q & ~pclk_d_q;

    // source select follows the applied pin input enable
    always_comb begin
        if (cfg_q.digital_pin_input_enable) begin
            src_stb   = pin_stb;
            src_frame = pin_s2_q.frame;
            src_line  = pin_s2_q.line;
            src_data  = pin_s2_q.data;
        end else begin
            src_stb   = csi_valid & fifo_in_ready;
            src_frame = csi_pix.frame;
            src_line  = csi_pix.line;
            src_data  = csi_pix.data;
        end
    end

    // serial stream is stalled by the buffer; pins cannot be
    assign csi_ready = ~cfg_q.digital_pin_input_enable & fifo_in_ready;

    // frame boundaries of the selected source
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            frame_d_q <= 1'b0;
        end else begin
            frame_d_q <= src_frame;
        end
    end

    assign sof = src_frame & ~frame_d_q;
    assign eof = ~src_frame & frame_d_q;

    ////////////////////////////////////////////////////////////////////////
    // soft reset held between assert and release pulses
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sreset_q <= 1'b0;
        end else if (soft_reset_release) begin
            sreset_q <= 1'b0;
        end else if (soft_reset_assert) begin
            sreset_q <= 1'b1;
        end
    end

    // applied control fields: direct, or deferred to the next frame start
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            cfg_q <= vcs_pkg::CFG_RST;
        end else if (sreset_q) begin
            cfg_q <= vcs_pkg::CFG_RST;
        end else if (!internal_update_mode || sof) begin
            cfg_q <= main_control_cfg;
        end
    end

    // every readback bit is a defined flop; no undefined read data exists here
    assign active_cfg = cfg_q;

    ////////////////////////////////////////////////////////////////////////
    // capture sequencing
    assign go = module_enable & (continuous_capture | (single_capture & ~sc_done_q));

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_q <= vcs_pkg::ST_IDLE;
        end else if (sreset_q) begin
            state_q <= vcs_pkg::ST_IDLE;
        end else begin
            case (state_q)
                vcs_pkg::ST_IDLE: begin
                    if (go) begin
                        state_q <= vcs_pkg::ST_ARM;
                    end
                end
                vcs_pkg::ST_ARM: begin
                    if (!go) begin
                        state_q <= vcs_pkg::ST_IDLE;
                    end else if (sof) begin
                        state_q <= vcs_pkg::ST_FRAME;
                    end
                end
                vcs_pkg::ST_FRAME: begin
                    if (eof) begin
                        state_q <= (module_enable & continuous_capture) ? vcs_pkg::ST_ARM : vcs_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= vcs_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // single capture is spent after one frame until software drops it
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sc_done_q <= 1'b0;
        end else if (!single_capture || sreset_q) begin
            sc_done_q <= 1'b0;
        end else if (state_q == vcs_pkg::ST_FRAME && eof) begin
            sc_done_q <= 1'b1;
        end
    end

    // field toggles each frame start when sync toggle is on
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            field_q <= 1'b0;
        end else if (sreset_q || !sync_field_toggle_enable) begin
            field_q <= 1'b0;
        end else if (sof) begin
            field_q <= ~field_q;
        end
    end

    assign field_id = field_q ^ cfg_q.field_output_control;

    ////////////////////////////////////////////////////////////////////////
    // pixel words into the buffer; pin words lost on full are flagged
    assign wr_want = (state_q == vcs_pkg::ST_FRAME) & src_line & src_stb;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            ovf_q <= 1'b0;
        end else begin
            ovf_q <= wr_want & ~fifo_in_ready;
        end
    end

    assign overflow = ovf_q;

    vcs_fifo #(
        .W     (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .clk       (clk),
        .rstn      (rstn),
        .flush     (sreset_q),
        .in_valid  (wr_want),
        .in_ready  (fifo_in_ready),
        .in_data   (src_data),
        .out_valid (out_valid),
        .out_ready (out_ready),
        .out_data  (out_data)
    );

    // busy until idle and every captured word has left
    assign capture_active = (state_q != vcs_pkg::ST_IDLE) | out_valid;

    // module stop acknowledged only once capture is quiet
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            stop_q <= 1'b0;
        end else begin
            stop_q <= module_stop_request & (stop_q | ~capture_active);
        end
    end

    assign module_stop_state = stop_q;

    ////////////////////////////////////////////////////////////////////////
    // assertions
    property p_cfg_hold;
        @(posedge clk) disable iff (!rstn)
        (internal_update_mode && !sof && !sreset_q) |=> $stable(cfg_q);
    endproperty
    a_cfg_hold: assert property (p_cfg_hold) else $error("deferred fields changed outside frame start");

    property p_cfg_apply;
        @(posedge clk) disable iff (!rstn)
        (internal_update_mode && sof && !sreset_q) |=> (cfg_q == $past(main_control_cfg));
    endproperty
    a_cfg_apply: assert property (p_cfg_apply) else $error("deferred fields not applied at frame start");

    property p_pin_switch_stuck;
        @(posedge clk) disable iff (!rstn)
        (internal_update_mode && !src_frame && !frame_d_q && !sreset_q) [*3]
            |-> $stable(cfg_q.digital_pin_input_enable);
    endproperty
    a_pin_switch_stuck: assert property (p_pin_switch_stuck) else $error("pin enable switched with no frame");

    property p_start;
        @(posedge clk) disable iff (!rstn)
        (state_q == vcs_pkg::ST_IDLE && go && !sreset_q) |=> (state_q == vcs_pkg::ST_ARM) ##1 capture_active;
    endproperty
    a_start: assert property (p_start) else $error("capture did not arm on enable");

    property p_single_once;
        @(posedge clk) disable iff (!rstn)
        (state_q == vcs_pkg::ST_FRAME && eof && single_capture && !continuous_capture && !sreset_q)
            ##1 !continuous_capture |-> (state_q == vcs_pkg::ST_IDLE) ##1 (state_q == vcs_pkg::ST_IDLE);
    endproperty
    a_single_once: assert property (p_single_once) else $error("single capture took a second frame");

    property p_frame_kept;
        @(posedge clk) disable iff (!rstn)
        (state_q == vcs_pkg::ST_FRAME && !eof && !sreset_q && !module_enable) |=> (state_q == vcs_pkg::ST_FRAME);
    endproperty
    a_frame_kept: assert property (p_frame_kept) else $error("frame abandoned on stop");

    property p_stop_quiet;
        @(posedge clk) disable iff (!rstn)
        $rose(module_stop_state) |-> !$past(capture_active) && !capture_active;
    endproperty
    a_stop_quiet: assert property (p_stop_quiet) else $error("stop state while capture active");

    c_frame_done: cover property (@(posedge clk) disable iff (!rstn) state_q == vcs_pkg::ST_FRAME ##1 eof);
    c_deferred:   cover property (@(posedge clk) disable iff (!rstn) internal_update_mode && sof);
    c_stopped:    cover property (@(posedge clk) disable iff (!rstn) $rose(module_stop_state));

endmodule // vcs_sequencer

`default_nettype wire

// ---- testbench/vcs_camera.sv ----
// Purpose: camera model on the parallel pins
// Assumes: pixel clock of 64 ns that runs only inside frames
// Notes:   data shows its inverse once a line is over
`default_nettype none

module vcs_camera (
    // pins toward the block
    output var logic                       pin_clk,
    output var logic                       pin_vsync,
    output var logic                       pin_hsync,
    output var logic [vcs_pkg::DATA_W-1:0] pin_data
);
    timeunit 1ns;
    timeprecision 100ps;

    // idle pins at time zero
    initial begin
        pin_clk   = 1'b0;
        pin_vsync = 1'b0;
        pin_hsync = 1'b0;
        pin_data  = 16'h0000;
    end

    ////////////////////////////////////////
    // one pixel clock period, data changes while the clock is low
    task automatic tick;
        #32 pin_clk = 1'b1;
        #32 pin_clk = 1'b0;
    endtask

    // one frame of a single line of n pixels counting up from base
    task automatic frame(input int n, input logic [15:0] base);
        pin_vsync = 1'b1;
        repeat (2) tick();
        for (int i = 0; i < n; i++) begin
            pin_hsync = 1'b1;
            pin_data  = base + 16'(i);
            tick();
        end
        pin_hsync = 1'b0;
        pin_data  = ~pin_data;
        tick();
        pin_vsync = 1'b0;
        #200;
    endtask
endmodule // vcs_camera

`default_nettype wire

// ---- testbench/vcs_sequencer_tb.sv ----
// Purpose: self-checking bench of the capture sequencer
// Assumes: bench drives the serial stream, camera model the pins
// Notes:   inputs change by non-blocking assignment at rising edges
`default_nettype none

module vcs_sequencer_tb;
    timeunit 1ns;
    timeprecision 100ps;

    logic              clk, rstn, module_enable, continuous_capture, single_capture;
    logic              internal_update_mode, sync_field_toggle_enable, module_stop_request;
    logic              soft_reset_assert, soft_reset_release, module_stop_state;
    logic              capture_active, field_id, overflow, pin_clk, pin_vsync, pin_hsync;
    logic              csi_valid, csi_ready, out_valid, out_ready;
    logic [15:0]       pin_data, out_data;
    vcs_pkg::vcs_cfg_t main_control_cfg, active_cfg;
    vcs_pkg::vcs_pix_t csi_pix;
    int                fail_count, comparisons, cycles, ovf_seen;

    vcs_sequencer i_vcs_sequencer (
        .clk, .rstn, .module_enable, .continuous_capture, .single_capture,
        .internal_update_mode, .main_control_cfg, .sync_field_toggle_enable,
        .module_stop_request, .soft_reset_assert, .soft_reset_release, .module_stop_state,
        .capture_active, .active_cfg, .field_id, .overflow, .pin_clk, .pin_vsync,
        .pin_hsync, .pin_data, .csi_valid, .csi_ready, .csi_pix, .out_valid,
        .out_ready, .out_data
    );
    vcs_camera i_vcs_camera (.pin_clk, .pin_vsync, .pin_hsync, .pin_data);

    // clock and hang guard
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            $display("wrong value at %0t: run timed out", $time);
            final_report();
        end
    end

    // lost pin words, counted where the pulse has settled
    always @(negedge clk) begin
        if (overflow === 1'b1) begin
            ovf_seen++;
        end
    end

    ////////////////////////////////////////
    // compares
    task automatic chk_bit(input logic got, input logic exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %b", $time, what, got);
        end
    endtask
    task automatic chk_val(input logic [15:0] got, input logic [15:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value at %0t: %s got %h want %h", $time, what, got, exp);
        end
    endtask

    // helpers, entered just after a rising edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    task automatic beat(input logic ln, input logic [15:0] d);
        csi_valid <= 1'b1;
        csi_pix   <= '{frame: 1'b1, line: ln, data: d};
        do @(negedge clk); while (!csi_ready);
        @(posedge clk);
    endtask
    task automatic pop(input logic [15:0] exp);
        out_ready <= 1'b1;
        @(negedge clk);
        chk_bit(out_valid, 1'b1, "out_valid");
        chk_val(out_data, exp, "out_data");
        @(posedge clk);
    endtask
    task automatic wait_idle;
        @(negedge clk);
        for (int i = 0; i < 100 && capture_active; i++) @(negedge clk);
        chk_bit(capture_active, 1'b0, "capture_active");
        @(posedge clk);
    endtask
    task automatic sreset;
        soft_reset_assert  <= 1'b1;
        cyc(1);
        soft_reset_assert  <= 1'b0;
        soft_reset_release <= 1'b1;
        cyc(1);
        soft_reset_release <= 1'b0;
        cyc(1);
    endtask

    ////////////////////////////////////////
    // scenarios
    task automatic t_reset;
        @(negedge clk);
        chk_bit(capture_active, 1'b0, "capture_active");
        chk_bit(csi_ready, 1'b1, "csi_ready");
        chk_val(16'(active_cfg), 16'h0000, "active_cfg");
        @(posedge clk);
    endtask

    task automatic t_csi;
        sync_field_toggle_enable <= 1'b1;
        module_enable <= 1'b1;
        cyc(1);
        single_capture <= 1'b1;
        cyc(1);
        @(negedge clk);
        chk_bit(capture_active, 1'b1, "armed");
        @(posedge clk);
        beat(1'b0, 16'h0000);
        for (int i = 0; i < 16; i++) beat(1'b1, 16'hA000 + 16'(i));
        module_stop_request <= 1'b1;
        cyc(2);
        @(negedge clk);
        chk_bit(csi_ready, 1'b0, "fifo full");
        chk_bit(module_stop_state, 1'b0, "stop while busy");
        @(posedge clk);
        csi_valid <= 1'b0;
        csi_pix <= '0;
        module_stop_request <= 1'b0;
        cyc(2);
        @(negedge clk);
        chk_bit(capture_active, 1'b1, "queued words");
        chk_bit(field_id, 1'b1, "field toggle");
        @(posedge clk);
        for (int i = 0; i < 16; i++) pop(16'hA000 + 16'(i));
        out_ready <= 1'b0;
        beat(1'b0, 16'h0000);
        beat(1'b1, 16'h1234);
        csi_valid <= 1'b0;
        csi_pix <= '0;
        cyc(2);
        @(negedge clk);
        chk_bit(out_valid, 1'b0, "second single frame");
        @(posedge clk);
        module_enable <= 1'b0;
        single_capture <= 1'b0;
        wait_idle();
    endtask

    task automatic t_defer;
        sreset();
        internal_update_mode <= 1'b1;
        main_control_cfg <= 7'h7F;
        i_vcs_camera.frame(4, 16'h0000);
        @(negedge clk);
        chk_val(16'(active_cfg), 16'h0000, "deferred switch");
        @(posedge clk);
        internal_update_mode <= 1'b0;
        cyc(2);
        @(negedge clk);
        chk_val(16'(active_cfg), 16'h007F, "direct update");
        chk_bit(csi_ready, 1'b0, "pins selected");
        @(posedge clk);
        internal_update_mode <= 1'b1;
        main_control_cfg <= 7'h55;
        cyc(3);
        @(negedge clk);
        chk_val(16'(active_cfg), 16'h007F, "held");
        i_vcs_camera.frame(4, 16'h0000);
        @(negedge clk);
        chk_val(16'(active_cfg), 16'h0055, "applied");
        @(posedge clk);
    endtask

    task automatic t_pin;
        module_enable <= 1'b1;
        continuous_capture <= 1'b1;
        cyc(2);
        i_vcs_camera.frame(4, 16'h0100);
        i_vcs_camera.frame(4, 16'h0200);
        @(posedge clk);
        module_enable <= 1'b0;
        continuous_capture <= 1'b0;
        cyc(2);
        @(negedge clk);
        chk_bit(capture_active, 1'b1, "queued pins");
        chk_val(16'(ovf_seen), 16'h0000, "no overflow");
        @(posedge clk);
        for (int i = 0; i < 8; i++) pop(16'((i / 4 + 1) * 256 + i % 4));
        out_ready <= 1'b0;
        wait_idle();
    endtask

    // one pin frame longer than the buffer: first words kept, the rest flagged
    task automatic t_overflow;
        module_enable <= 1'b1;
        single_capture <= 1'b1;
        cyc(2);
        i_vcs_camera.frame(20, 16'h0300);
        @(posedge clk);
        module_enable <= 1'b0;
        single_capture <= 1'b0;
        cyc(2);
        @(negedge clk);
        chk_val(16'(ovf_seen), 16'h0004, "lost words");
        @(posedge clk);
        for (int i = 0; i < 16; i++) pop(16'h0300 + 16'(i));
        out_ready <= 1'b0;
        wait_idle();
    endtask

    task automatic t_standby;
        module_stop_request <= 1'b1;
        cyc(2);
        @(negedge clk);
        chk_bit(module_stop_state, 1'b1, "stop state");
        @(posedge clk);
        module_stop_request <= 1'b0;
        cyc(2);
        @(negedge clk);
        chk_bit(module_stop_state, 1'b0, "stop left");
        @(posedge clk);
        sreset();
        @(negedge clk);
        chk_val(16'(active_cfg), 16'h0000, "soft reset");
        chk_bit(field_id, 1'b0, "field cleared");
    endtask

    task automatic final_report;
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // main sequence
    initial begin
        {rstn, module_enable, continuous_capture, single_capture} = 4'h0;
        {internal_update_mode, sync_field_toggle_enable, module_stop_request} = 3'h0;
        {soft_reset_assert, soft_reset_release, csi_valid, out_ready} = 4'h0;
        main_control_cfg = '0;
        csi_pix = '0;
        fail_count = 0;
        comparisons = 0;
        cycles = 0;
        ovf_seen = 0;
        cyc(10);
        rstn <= 1'b1;
        cyc(1);
        t_reset();
        t_csi();
        t_defer();
        t_pin();
        t_overflow();
        t_standby();
        final_report();
    end
endmodule // vcs_sequencer_tb

`default_nettype wire
